//--- design/tpiw_defines.vh
// register offsets, field layouts and reset values of the two-port i/o block
`ifndef TPIW_DEFINES_VH
`define TPIW_DEFINES_VH

`define TPIW_ADDR_W 8
`define TPIW_DATA_W 8

`define TPIW_OFS_PORT_A_DATA 8'h00
`define TPIW_OFS_PORT_A_DIR 8'h01
`define TPIW_OFS_PORT_A_PULL 8'h02
`define TPIW_OFS_PORT_A_WAKE 8'h03
`define TPIW_OFS_PORT_B_DATA 8'h04
`define TPIW_OFS_PORT_B_DIR 8'h05
`define TPIW_OFS_PORT_B_PULL 8'h06
`define TPIW_OFS_PORT_A_FSEL 8'h07
`define TPIW_OFS_PORT_B_FSEL 8'h08
`define TPIW_OFS_SRC_SEL 8'h09

`define TPIW_RST_PORT_A_DATA 8'hF7
`define TPIW_RST_PORT_A_DIR 8'hF7
`define TPIW_RST_PORT_A_PULL 8'h00
`define TPIW_RST_PORT_A_WAKE 3'h0
`define TPIW_RST_PORT_B_DATA 2'h3
`define TPIW_RST_PORT_B_DIR 2'h3
`define TPIW_RST_PORT_B_PULL 2'h0
`define TPIW_RST_PORT_A_FSEL 6'h00
`define TPIW_RST_PORT_B_FSEL 4'h0
`define TPIW_RST_SRC_SEL 4'h0

`define TPIW_PORT_A_MASK 8'hF7
`define TPIW_UNIMPL_BIT 3
`define TPIW_FSEL_ALT 2'h3
`define TPIW_SRC_FIXED_PIN 1'b0
`define TPIW_SRC_IDLE_LEVEL 1'b1

`endif

//--- design/tpiw_pin_cell.v
// one general purpose pin: direction, output mux, pull-high gating and read path
`timescale 1ns/10ps
module tpiw_pin_cell (
  input wire latch_bit,
  input wire dir_bit,
  input wire pull_bit,
  input wire alt_sel,
  input wire alt_out,
  input wire alt_oe,
  input wire pin_in,
  output wire pin_out,
  output wire pin_oe,
  output wire pin_pull,
  output wire read_bit,
  output wire gpio_input
);
  // 0 drives cmos output, 1 makes an input; a selected peripheral takes over
  assign pin_oe = alt_sel ? alt_oe : ~dir_bit; // R03
  assign pin_out = alt_sel ? alt_out : latch_bit; // R02
  // pull-high only while nobody drives the pin (input or released open drain)
  assign pin_pull = pull_bit & ~pin_oe; // R05 R06
  // inputs read the live pin, outputs read back the latch
  assign read_bit = dir_bit ? pin_in : latch_bit; // R01 R04
  assign gpio_input = ~alt_sel & dir_bit;
endmodule // tpiw_pin_cell

//--- design/tpiw_wake_detect.v
// falling-edge wake-up detector for the first port
`timescale 1ns/10ps
module tpiw_wake_detect #(
  parameter WIDTH = 3
) (
  input wire clk,
  input wire nrst,
  input wire [WIDTH-1:0] pin_in,
  input wire [WIDTH-1:0] wake_en,
  input wire [WIDTH-1:0] gpio_input,
  input wire low_power,
  output wire wake_req
);
  reg [WIDTH-1:0] prev_q;
  reg wake_q;
  wire [WIDTH-1:0] fall;

  // enable counts only for general inputs while idle or sleeping
  assign fall = prev_q & ~pin_in & wake_en & gpio_input; // R07 R08

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prev_q <= {WIDTH{1'b1}};
      wake_q <= 1'b0;
    end else begin
      prev_q <= pin_in;
      wake_q <= low_power & (|fall); // R08 R22
    end
  end

  assign wake_req = wake_q;
endmodule // tpiw_wake_detect

//--- design/tpiw_top.v
// two-port general purpose i/o with pull-high, function select and wake-up
// Operation
// R01: port reads sample pin levels directly at the read edge, no input latch.
// R02: each output bit sits in a data latch until software rewrites it.
// R03: direction bit 0 makes a cmos output, 1 makes a readable input.
// R04: reading an output pin returns its data latch, not the pin level.
// R05: pull-high bit 0 disables, 1 enables the weak pull-high.
// R06: pull-high acts only for digital inputs or released open-drain outputs.
// R07: falling edge on a wake-enabled first-port pin wakes the device.
// R08: wake enable works only for general inputs while idle or sleeping.
// R09: wake register low three bits enable wake-up per first-port pin.
// R10: wake register upper four bits are reserved and cannot be changed.
// R11: wake register bit 3 is unimplemented and reads zero.
// R12: software clears reserved upper first-port direction bits after power-on.
// R13: software leaves reserved upper first-port pull-high bits unchanged.
// R14: select pin function first, then configure, then enable the peripheral.
// R15: digital input functions also need the pin's direction bit set to input.
// R16: release a function by disabling the peripheral before changing selection.
// R17: two memory-mapped ports: first has pins 0-2, second has pins 0-1.
// R18: reset sets all data latches and direction bits high.
// R19: first-port select code 11 routes pin to serial function, else general.
// R20: second-port select code 11 routes pin to pwm output, else general.
// R21: input source bit 0 takes serial input from its fixed first-port pin.
// R22: wake request is the or of all enabled falling-edge detections.
`timescale 1ns/10ps
`include "tpiw_defines.vh"
module tpiw_top #(
  parameter FP_PINS = 3,
  parameter SP_PINS = 2
) (
  input wire clk,
  input wire nrst,
  input wire [`TPIW_ADDR_W-1:0] mem_addr,
  input wire mem_wr,
  input wire mem_rd,
  input wire [`TPIW_DATA_W-1:0] mem_wdata,
  output wire [`TPIW_DATA_W-1:0] mem_rdata,
  input wire [FP_PINS-1:0] fp_pin_in,
  output wire [FP_PINS-1:0] fp_pin_out,
  output wire [FP_PINS-1:0] fp_pin_oe,
  output wire [FP_PINS-1:0] fp_pin_pull,
  input wire [SP_PINS-1:0] sp_pin_in,
  output wire [SP_PINS-1:0] sp_pin_out,
  output wire [SP_PINS-1:0] sp_pin_oe,
  output wire [SP_PINS-1:0] sp_pin_pull,
  input wire [FP_PINS-1:0] serial_pin_out,
  input wire [FP_PINS-1:0] serial_pin_oe,
  input wire [SP_PINS-1:0] pwm_out,
  output wire serial_clk_in,
  output wire serial_data_in,
  output wire serial_cs_in,
  output wire ext_int_in,
  output wire event_count_input,
  input wire low_power,
  output wire wake_req
);
  reg [7:0] port_a_data_q;
  reg [7:0] port_a_direction_q;
  reg [7:0] port_a_pullhigh_q;
  reg [2:0] port_a_wakeup_enable_q;
  reg [1:0] port_b_data_q;
  reg [1:0] port_b_direction_q;
  reg [1:0] port_b_pullhigh_q;
  reg [5:0] port_a_function_select_q;
  reg [3:0] port_b_function_select_q;
  reg [3:0] input_source_select_q;
  reg [`TPIW_DATA_W-1:0] mem_rdata_q;
  reg [`TPIW_DATA_W-1:0] mem_rdata_d;

  wire [FP_PINS-1:0] fp_read;
  wire [FP_PINS-1:0] fp_gpio_input;
  wire [FP_PINS-1:0] fp_alt_sel;
  wire [SP_PINS-1:0] sp_read;
  wire [SP_PINS-1:0] sp_alt_sel;
  wire [SP_PINS-1:0] sp_gpio_input;
  wire [7:0] fp_read_byte;
  wire [7:0] sp_read_byte;

  // register writes from the data memory bus
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      port_a_data_q <= `TPIW_RST_PORT_A_DATA; // R18
      port_a_direction_q <= `TPIW_RST_PORT_A_DIR; // R18
      port_a_pullhigh_q <= `TPIW_RST_PORT_A_PULL;
      port_a_wakeup_enable_q <= `TPIW_RST_PORT_A_WAKE;
      port_b_data_q <= `TPIW_RST_PORT_B_DATA; // R18
      port_b_direction_q <= `TPIW_RST_PORT_B_DIR; // R18
      port_b_pullhigh_q <= `TPIW_RST_PORT_B_PULL;
      port_a_function_select_q <= `TPIW_RST_PORT_A_FSEL;
      port_b_function_select_q <= `TPIW_RST_PORT_B_FSEL;
      input_source_select_q <= `TPIW_RST_SRC_SEL;
    end else if (mem_wr) begin
      if (mem_addr == `TPIW_OFS_PORT_A_DATA) begin
        // bit 3 has no latch and stays zero
        port_a_data_q <= mem_wdata & `TPIW_PORT_A_MASK; // R02 R17
      end else if (mem_addr == `TPIW_OFS_PORT_A_DIR) begin
        port_a_direction_q <= mem_wdata & `TPIW_PORT_A_MASK; // R17
      end else if (mem_addr == `TPIW_OFS_PORT_A_PULL) begin
        port_a_pullhigh_q <= mem_wdata & `TPIW_PORT_A_MASK; // R17
      end else if (mem_addr == `TPIW_OFS_PORT_A_WAKE) begin
        // only the three enables are writable
        port_a_wakeup_enable_q <= mem_wdata[2:0]; // R09 R10
      end else if (mem_addr == `TPIW_OFS_PORT_B_DATA) begin
        port_b_data_q <= mem_wdata[1:0]; // R02 R17
      end else if (mem_addr == `TPIW_OFS_PORT_B_DIR) begin
        port_b_direction_q <= mem_wdata[1:0];
      end else if (mem_addr == `TPIW_OFS_PORT_B_PULL) begin
        port_b_pullhigh_q <= mem_wdata[1:0];
      end else if (mem_addr == `TPIW_OFS_PORT_A_FSEL) begin
        port_a_function_select_q <= mem_wdata[5:0];
      end else if (mem_addr == `TPIW_OFS_PORT_B_FSEL) begin
        port_b_function_select_q <= mem_wdata[3:0];
      end else if (mem_addr == `TPIW_OFS_SRC_SEL) begin
        input_source_select_q <= mem_wdata[3:0];
      end
    end
  end

  // first port pins
  genvar i;
  generate
    for (i = 0; i < FP_PINS; i = i + 1) begin : g_fp
      // code 11 hands the pin to the serial interface
      assign fp_alt_sel[i] = (port_a_function_select_q[2*i+1:2*i] == `TPIW_FSEL_ALT); // R19
      tpiw_pin_cell u_cell (
        .latch_bit(port_a_data_q[i]),
        .dir_bit(port_a_direction_q[i]),
        .pull_bit(port_a_pullhigh_q[i]),
        .alt_sel(fp_alt_sel[i]),
        .alt_out(serial_pin_out[i]),
        .alt_oe(serial_pin_oe[i]),
        .pin_in(fp_pin_in[i]),
        .pin_out(fp_pin_out[i]),
        .pin_oe(fp_pin_oe[i]),
        .pin_pull(fp_pin_pull[i]),
        .read_bit(fp_read[i]),
        .gpio_input(fp_gpio_input[i])
      );
    end
    // second port pins
    for (i = 0; i < SP_PINS; i = i + 1) begin : g_sp
      // code 11 hands the pin to the pwm output, always driven
      assign sp_alt_sel[i] = (port_b_function_select_q[2*i+1:2*i] == `TPIW_FSEL_ALT); // R20
      tpiw_pin_cell u_cell (
        .latch_bit(port_b_data_q[i]),
        .dir_bit(port_b_direction_q[i]),
        .pull_bit(port_b_pullhigh_q[i]),
        .alt_sel(sp_alt_sel[i]),
        .alt_out(pwm_out[i]),
        .alt_oe(1'b1),
        .pin_in(sp_pin_in[i]),
        .pin_out(sp_pin_out[i]),
        .pin_oe(sp_pin_oe[i]),
        .pin_pull(sp_pin_pull[i]),
        .read_bit(sp_read[i]),
        .gpio_input(sp_gpio_input[i])
      );
    end
  endgenerate

  // unbonded upper bits read back their latches; bit 3 reads zero
  assign fp_read_byte = {port_a_data_q[7:4], 1'b0, fp_read}; // R01 R04 R17
  assign sp_read_byte = {6'h00, sp_read}; // R17

  // serial inputs come from the fixed first-port pins; value 1 is reserved
  assign serial_clk_in = (input_source_select_q[0] == `TPIW_SRC_FIXED_PIN) ?
    fp_pin_in[0] : `TPIW_SRC_IDLE_LEVEL; // R21
  assign serial_data_in = (input_source_select_q[1] == `TPIW_SRC_FIXED_PIN) ?
    fp_pin_in[2] : `TPIW_SRC_IDLE_LEVEL; // R21
  assign serial_cs_in = (input_source_select_q[2] == `TPIW_SRC_FIXED_PIN) ?
    fp_pin_in[1] : `TPIW_SRC_IDLE_LEVEL; // R21

  // digital input functions share the general i/o selection
  assign ext_int_in = fp_pin_in[0]; // R15
  assign event_count_input = fp_pin_in[1]; // R15

  // read decode; unmapped addresses read zero
  always @* begin
    mem_rdata_d = 8'h00;
    if (mem_addr == `TPIW_OFS_PORT_A_DATA) begin
      mem_rdata_d = fp_read_byte;
    end else if (mem_addr == `TPIW_OFS_PORT_A_DIR) begin
      mem_rdata_d = port_a_direction_q;
    end else if (mem_addr == `TPIW_OFS_PORT_A_PULL) begin
      mem_rdata_d = port_a_pullhigh_q;
    end else if (mem_addr == `TPIW_OFS_PORT_A_WAKE) begin
      // reserved upper bits hold zero, bit 3 reads zero
      mem_rdata_d = {4'h0, 1'b0, port_a_wakeup_enable_q}; // R10 R11
    end else if (mem_addr == `TPIW_OFS_PORT_B_DATA) begin
      mem_rdata_d = sp_read_byte;
    end else if (mem_addr == `TPIW_OFS_PORT_B_DIR) begin
      mem_rdata_d = {6'h00, port_b_direction_q};
    end else if (mem_addr == `TPIW_OFS_PORT_B_PULL) begin
      mem_rdata_d = {6'h00, port_b_pullhigh_q};
    end else if (mem_addr == `TPIW_OFS_PORT_A_FSEL) begin
      mem_rdata_d = {2'h0, port_a_function_select_q};
    end else if (mem_addr == `TPIW_OFS_PORT_B_FSEL) begin
      mem_rdata_d = {4'h0, port_b_function_select_q};
    end else if (mem_addr == `TPIW_OFS_SRC_SEL) begin
      mem_rdata_d = {4'h0, input_source_select_q};
    end
  end

  // pins are sampled at the read edge itself, nothing latches them earlier
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mem_rdata_q <= 8'h00;
    end else if (mem_rd) begin
      mem_rdata_q <= mem_rdata_d; // R01
    end
  end

  assign mem_rdata = mem_rdata_q;

  tpiw_wake_detect #(
    .WIDTH(FP_PINS)
  ) u_wake (
    .clk(clk),
    .nrst(nrst),
    .pin_in(fp_pin_in),
    .wake_en(port_a_wakeup_enable_q),
    .gpio_input(fp_gpio_input),
    .low_power(low_power),
    .wake_req(wake_req)
  ); // R07 R22
endmodule // tpiw_top

//--- dv/tpiw_props.sv
// assertion checker for the two-port i/o block
`timescale 1ns/10ps
module tpiw_props #(
  parameter FP_PINS = 3,
  parameter SP_PINS = 2
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] mem_addr,
  input wire logic mem_wr,
  input wire logic mem_rd,
  input wire logic [7:0] mem_rdata,
  input wire logic [FP_PINS-1:0] fp_pin_in,
  input wire logic [FP_PINS-1:0] fp_pin_out,
  input wire logic [FP_PINS-1:0] fp_pin_oe,
  input wire logic [FP_PINS-1:0] fp_pin_pull,
  input wire logic [SP_PINS-1:0] sp_pin_out,
  input wire logic [SP_PINS-1:0] sp_pin_oe,
  input wire logic [SP_PINS-1:0] sp_pin_pull,
  input wire logic [FP_PINS-1:0] serial_pin_out,
  input wire logic [FP_PINS-1:0] serial_pin_oe,
  input wire logic [SP_PINS-1:0] pwm_out,
  input wire logic low_power,
  input wire logic wake_req
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  property p_rst;
    $rose(nrst) |-> fp_pin_oe == 0 && sp_pin_oe == 0 && fp_pin_out == '1;
  endproperty
  a_rst: assert property (p_rst) else $error("pins not idle after reset");
  property p_pull;
    (fp_pin_pull & fp_pin_oe) == 0 && (sp_pin_pull & sp_pin_oe) == 0;
  endproperty
  a_pull: assert property (p_pull) else $error("pull-high on a driven pin");
  property p_wake;
    wake_req |-> $past(low_power) && ($past(fp_pin_in, 2) & ~$past(fp_pin_in) & ~$past(fp_pin_oe)) != 0;
  endproperty
  a_wake: assert property (p_wake) else $error("wake request without a falling input");
  property p_sleep;
    !low_power |=> !wake_req;
  endproperty
  a_sleep: assert property (p_sleep) else $error("wake request while running");
  property p_wreg;
    mem_rd && mem_addr == 8'h03 |=> mem_rdata[7:3] == 5'h00;
  endproperty
  a_wreg: assert property (p_wreg) else $error("wake register upper bits not zero");
  property p_pa3;
    mem_rd && mem_addr == 8'h00 |=> !mem_rdata[3];
  endproperty
  a_pa3: assert property (p_pa3) else $error("first port bit 3 not zero");
  property p_pb;
    mem_rd && mem_addr == 8'h04 |=> mem_rdata[7:2] == 6'h00;
  endproperty
  a_pb: assert property (p_pb) else $error("second port upper bits not zero");
  property p_out;
    !$past(mem_wr) && $stable(serial_pin_out) && $stable(pwm_out) |-> $stable(fp_pin_out) && $stable(sp_pin_out);
  endproperty
  a_out: assert property (p_out) else $error("output moved without a write");
  property p_oe;
    !$past(mem_wr) && $stable(serial_pin_oe) |-> $stable(fp_pin_oe) && $stable(sp_pin_oe);
  endproperty
  a_oe: assert property (p_oe) else $error("direction moved without a write");
  c_wake: cover property (wake_req);
  c_rd: cover property (mem_rd && mem_addr == 8'h00);
  c_pull: cover property (fp_pin_pull != 0);
endmodule // tpiw_props
bind tpiw_top tpiw_props #(.FP_PINS(FP_PINS), .SP_PINS(SP_PINS)) u_tpiw_props (.clk(clk),
  .nrst(nrst), .mem_addr(mem_addr), .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_rdata(mem_rdata),
  .fp_pin_in(fp_pin_in), .fp_pin_out(fp_pin_out), .fp_pin_oe(fp_pin_oe),
  .fp_pin_pull(fp_pin_pull), .sp_pin_out(sp_pin_out), .sp_pin_oe(sp_pin_oe),
  .sp_pin_pull(sp_pin_pull), .serial_pin_out(serial_pin_out), .serial_pin_oe(serial_pin_oe),
  .pwm_out(pwm_out), .low_power(low_power), .wake_req(wake_req));

//--- dv/tpiw_pin_env.sv
// external pin model: switches, weak pull-high and floating lines
`timescale 1ns/10ps
module tpiw_pin_env #(
  parameter W = 3
) (
  input wire logic clk,
  input wire logic [W-1:0] pin_out,
  input wire logic [W-1:0] pin_oe,
  input wire logic [W-1:0] pin_pull,
  input wire logic sw_en,
  input wire logic [W-1:0] sw_val,
  output wire logic [W-1:0] pin_lvl
);
  logic flt = 1'b0;
  always @(posedge clk) begin
    flt <= ~flt;
  end
  // driven pin wins, then switch, then pull-high, else a floating level
  assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & {W{sw_en}} & sw_val) |
    (~pin_oe & {W{~sw_en}} & (pin_pull | {W{flt}}));
endmodule // tpiw_pin_env

//--- dv/tb_top.sv
// self-checking bench for the two-port i/o block
`timescale 1ns/10ps
module tb_top;
  logic clk = 0, nrst = 0, mem_wr = 0, mem_rd = 0, low_power = 0, sw_en = 1;
  logic [7:0] mem_addr = 8'h00, mem_wdata = 8'h00;
  logic [2:0] sw_val = 3'h7, serial_pin_out = 3'h0, serial_pin_oe = 3'h0;
  logic [1:0] sp_sw = 2'h3, pwm_out = 2'h0;
  wire [7:0] mem_rdata;
  wire [2:0] fp_pin_in, fp_pin_out, fp_pin_oe, fp_pin_pull;
  wire [1:0] sp_pin_in, sp_pin_out, sp_pin_oe, sp_pin_pull;
  wire serial_clk_in, serial_data_in, serial_cs_in, wake_req, ext_int_in, ev_cnt_in;
  int err_total = 0, n_tests = 0, cyc = 0;
  initial begin
    forever #12.5 clk = ~clk;
  end
  tpiw_top u_tpiw_top (.clk(clk), .nrst(nrst), .mem_addr(mem_addr), .mem_wr(mem_wr),
    .mem_rd(mem_rd), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .fp_pin_in(fp_pin_in),
    .fp_pin_out(fp_pin_out), .fp_pin_oe(fp_pin_oe), .fp_pin_pull(fp_pin_pull),
    .sp_pin_in(sp_pin_in), .sp_pin_out(sp_pin_out), .sp_pin_oe(sp_pin_oe),
    .sp_pin_pull(sp_pin_pull), .serial_pin_out(serial_pin_out), .serial_pin_oe(serial_pin_oe),
    .pwm_out(pwm_out), .serial_clk_in(serial_clk_in), .serial_data_in(serial_data_in),
    .serial_cs_in(serial_cs_in), .ext_int_in(ext_int_in), .event_count_input(ev_cnt_in),
    .low_power(low_power),
    .wake_req(wake_req));
  tpiw_pin_env #(.W(3)) u_fp_env (.clk(clk), .pin_out(fp_pin_out), .pin_oe(fp_pin_oe),
    .pin_pull(fp_pin_pull), .sw_en(sw_en), .sw_val(sw_val), .pin_lvl(fp_pin_in));
  tpiw_pin_env #(.W(2)) u_sp_env (.clk(clk), .pin_out(sp_pin_out), .pin_oe(sp_pin_oe),
    .pin_pull(sp_pin_pull), .sw_en(sw_en), .sw_val(sp_sw), .pin_lvl(sp_pin_in));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1 {mem_wr, mem_addr, mem_wdata} = {1'b1, a, d};
    @(posedge clk) #1 mem_wr = 0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk) #1 {mem_rd, mem_addr} = {1'b1, a};
    @(posedge clk) #1 mem_rd = 0;
    chk(mem_rdata, exp);
  endtask
  task t_reset;
    logic [7:0] ofs [8] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09};
    logic [7:0] rv [8] = '{8'hF7, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 8; i++) rd(ofs[i], rv[i]);
    rd(8'h04, 8'h03);
    $display("reset values done");
  endtask
  task t_latch;
    wr(8'h00, 8'h5A);
    wr(8'h01, 8'h00);
    chk(fp_pin_oe, 8'h07);
    chk(fp_pin_out, 8'h02);
    rd(8'h00, 8'h52);
    wr(8'h01, 8'h07);
    sw_val = 3'h5;
    rd(8'h00, 8'h55);
    $display("latch and direction done");
  endtask
  task t_pull;
    wr(8'h02, 8'h07);
    chk(fp_pin_pull, 8'h07);
    sw_en = 0;
    rd(8'h00, 8'h57);
    wr(8'h01, 8'h00);
    chk(fp_pin_pull, 8'h00);
    wr(8'h01, 8'h07);
    sw_en = 1;
    wr(8'h02, 8'h00);
    wr(8'h06, 8'h03);
    chk(sp_pin_pull, 8'h03);
    wr(8'h06, 8'h00);
    $display("pull-high done");
  endtask
  task t_wake;
    wr(8'h03, 8'hFF);
    rd(8'h03, 8'h07);
    {low_power, sw_val} = 4'hF;
    repeat (2) @(posedge clk);
    #1 sw_val = 3'h3;
    @(posedge clk) #1 chk(wake_req, 8'h01);
    @(posedge clk) #1 chk(wake_req, 8'h00);
    {low_power, sw_val} = 4'h7;
    repeat (2) @(posedge clk);
    #1 sw_val = 3'h6;
    repeat (2) @(posedge clk);
    #1 chk(wake_req, 8'h00);
    wr(8'h03, 8'h00);
    $display("wake-up done");
  endtask
  task t_func;
    wr(8'h07, 8'h3F);
    wr(8'h08, 8'h0F);
    {serial_pin_oe, serial_pin_out, pwm_out} = 8'hF6;
    #1 chk(fp_pin_out, 8'h05);
    chk(fp_pin_oe, 8'h07);
    chk(sp_pin_out, 8'h02);
    chk(sp_pin_oe, 8'h03);
    {serial_pin_oe, sw_val} = 6'h02;
    #1 chk({serial_data_in, serial_cs_in, serial_clk_in}, 8'h02);
    chk({ev_cnt_in, ext_int_in}, 8'h02);
    wr(8'h09, 8'h07);
    chk({serial_data_in, serial_cs_in, serial_clk_in}, 8'h07);
    wr(8'h07, 8'h00);
    wr(8'h08, 8'h00);
    wr(8'h0A, 8'hFF);
    rd(8'h0A, 8'h00);
    $display("function select done");
  endtask
  task results;
    $display("comparisons=%0d mismatches=%0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      err_total++;
      results();
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    #1 nrst = 1;
    t_reset();
    t_latch();
    t_pull();
    t_wake();
    t_func();
    results();
  end
endmodule // tb_top
